// file: ddtr_byte_reg.sv
// Masked byte-wide configuration register
`timescale 1ns/1ps
module ddtr_byte_reg
  import ddtr_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q_reg
);

  logic [7:0] q_next;

  // ==========================================================================
  // Next value keeps reserved bits at zero
  assign q_next = wr_en ? (wdata & MASK) : q_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      q_reg <= CFG_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// file: ddtr_code_chan.sv
// One channel: 12-bit conversion code, empty flag and byte views
`timescale 1ns/1ps
module ddtr_code_chan
  import ddtr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              left_align,
  input  wire logic              commit,
  input  wire logic [7:0]        temp_byte,
  input  wire logic [7:0]        wdata,
  input  wire logic              consume,
  output logic      [CODE_W-1:0] code_reg,
  output logic                   empty_reg,
  output logic      [7:0]        low_rd,
  output logic      [7:0]        high_rd
);

  logic [CODE_W-1:0] code_next;
  logic              empty_next;

  // ==========================================================================
  // Code assembled from staged low byte and written high byte
  assign code_next = !commit    ? code_reg :
                     left_align ? {wdata, temp_byte[7:4]} :
                                  {wdata[3:0], temp_byte};

  // Converter take sets the flag and wins over a new write
  assign empty_next = consume ? 1'b1 : (commit ? 1'b0 : empty_reg);

  // Byte views of the code in the selected layout
  assign low_rd  = left_align ? {code_reg[3:0], NIBBLE_ZERO} : code_reg[7:0];
  assign high_rd = left_align ? code_reg[11:4] : {NIBBLE_ZERO, code_reg[11:8]};

  always_ff @(posedge mclk) begin
    if (srst) begin
      code_reg  <= CODE_RESET;
      empty_reg <= 1'b0;
    end else begin
      code_reg  <= code_next;
      empty_reg <= empty_next;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_commit_right_code: assert property (commit && !left_align |=>
      code_reg == {$past(wdata[3:0]), $past(temp_byte)})
    else $error("right layout commit wrong");
  a_commit_left_code: assert property (commit && left_align |=>
      code_reg == {$past(wdata), $past(temp_byte[7:4])})
    else $error("left layout commit wrong");
  a_code_hold: assert property (!commit |=> $stable(code_reg))
    else $error("code changed without write");
  a_empty_order: assert property (consume |=> empty_reg
      and (!commit |=> empty_reg))
    else $error("empty flag not set by take");
  a_empty_clear: assert property (commit && !consume |=> !empty_reg)
    else $error("empty flag not cleared by write");

  c_overwrite: cover property (!empty_reg && commit);
endmodule

// file: ddtr_pkg.sv
// Constants, register map and helpers for the converter data and trim register bank
// ==========================================================================
// Summary of operation
// - Right layout: high byte bits 3:0, 7:4 zero
// - Left layout: high byte holds code 11:4
// - Right layout: low byte holds code 7:0
// - Left layout: low bits 7:4, 3:0 zero
// - Channel 0 gain trim, 8-bit read/write
// - Channel 0 offset trim, 8-bit read/write
// - Channel 1 gain trim, 7-bit, bit 7 zero
// - Channel 1 offset trim, 7-bit, bit 7 zero
// - Same map both layouts, code bytes 0x18-0x1b
// - One align bit selects left or right
// - Left layout: high byte write converts alone
// - Empty flag; write while clear overwrites code
package ddtr_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MAIN_CTRL  = 6'h00;
  localparam logic [5:0] IDX_TRIG_CTRL  = 6'h01;
  localparam logic [5:0] IDX_REF_ALIGN  = 6'h02;
  localparam logic [5:0] IDX_EVENT_SEL  = 6'h03;
  localparam logic [5:0] IDX_EMPTY_FLG  = 6'h05;
  localparam logic [5:0] IDX_CH0_GAIN   = 6'h08;
  localparam logic [5:0] IDX_CH0_OFFS   = 6'h09;
  localparam logic [5:0] IDX_CH1_GAIN   = 6'h0a;
  localparam logic [5:0] IDX_CH1_OFFS   = 6'h0b;
  localparam logic [5:0] IDX_CH0_LOW    = 6'h18;
  localparam logic [5:0] IDX_CH0_HIGH   = 6'h19;
  localparam logic [5:0] IDX_CH1_LOW    = 6'h1a;
  localparam logic [5:0] IDX_CH1_HIGH   = 6'h1b;

  // ==========================================================================
  // Byte-wide configuration registers, in generate order
  localparam int         NUM_CFG        = 8;
  localparam int         CFG_MAIN       = 0;
  localparam int         CFG_TRIG       = 1;
  localparam int         CFG_REFAL      = 2;
  localparam int         CFG_EVSEL      = 3;
  localparam int         CFG_G0         = 4;
  localparam int         CFG_O0         = 5;
  localparam int         CFG_G1         = 6;
  localparam int         CFG_O1         = 7;
  localparam logic [NUM_CFG-1:0][5:0] CFG_IDX = {
    IDX_CH1_OFFS, IDX_CH1_GAIN, IDX_CH0_OFFS, IDX_CH0_GAIN,
    IDX_EVENT_SEL, IDX_REF_ALIGN, IDX_TRIG_CTRL, IDX_MAIN_CTRL};
  // Writable bit masks; reserved bits hold zero
  localparam logic [NUM_CFG-1:0][7:0] CFG_MASK = {
    8'h7f, 8'h7f, 8'hff, 8'hff, 8'h0f, 8'h19, 8'h63, 8'h1f};
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // ==========================================================================
  // Field positions and widths
  localparam int         ALIGN_BIT      = 0;
  localparam int         CODE_W         = 12;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [7:0] TEMP_RESET     = 8'h00;
  localparam logic [3:0] NIBBLE_ZERO    = 4'h0;
  localparam int         ADDR_W         = 8;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] ddtr_addr(input logic [5:0] idx);
    ddtr_addr = {idx, 2'b00};
  endfunction

endpackage

// file: ddtr_top.sv
// Converter data and trim register bank with APB slave port
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module ddtr_top
  import ddtr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        code_taken,
  output logic      [7:0]        main_control,
  output logic      [7:0]        channel_trigger_control,
  output logic      [7:0]        reference_align_control,
  output logic      [7:0]        event_source_select,
  output logic      [7:0]        ch0_gain_trim,
  output logic      [7:0]        ch0_offset_trim,
  output logic      [7:0]        ch1_gain_trim,
  output logic      [7:0]        ch1_offset_trim,
  output logic      [CODE_W-1:0] ch0_conversion_code,
  output logic      [CODE_W-1:0] ch1_conversion_code,
  output logic                   ch0_code_empty_flag,
  output logic                   ch1_code_empty_flag
);

  logic [NUM_CFG-1:0][7:0] cfg_q;
  logic [NUM_CFG-1:0]      cfg_hit;
  logic [NUM_CFG-1:0]      cfg_wr;
  logic [1:0][7:0]         low_rd;
  logic [1:0][7:0]         high_rd;
  logic [1:0][CODE_W-1:0]  code_q;
  logic [1:0]              empty_q;
  logic [1:0]              low_hit;
  logic [1:0]              high_hit;
  logic [1:0]              high_wr;
  logic                    left_align_select;
  logic                    setup_ph;
  logic                    wr_strobe;
  logic                    status_hit;
  logic                    mapped;
  logic [7:0]              rd_byte;
  logic [7:0]              temp_reg;
  logic [7:0]              temp_next;
  logic [31:0]             prdata_reg;
  logic [31:0]             prdata_next;
  logic                    pready_reg;
  logic                    pready_next;
  logic                    pslverr_reg;
  logic                    pslverr_next;

  // ==========================================================================
  // APB phases; answer is registered in setup, write lands in access
  assign setup_ph  = psel && !penable;
  assign wr_strobe = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // ==========================================================================
  // Address decode, same map in both layouts
  assign low_hit[0]  = paddr == ddtr_addr(IDX_CH0_LOW);
  assign high_hit[0] = paddr == ddtr_addr(IDX_CH0_HIGH);
  assign low_hit[1]  = paddr == ddtr_addr(IDX_CH1_LOW);
  assign high_hit[1] = paddr == ddtr_addr(IDX_CH1_HIGH);
  assign status_hit  = paddr == ddtr_addr(IDX_EMPTY_FLG);
  assign mapped      = (|cfg_hit) || (|low_hit) || (|high_hit) || status_hit;
  assign high_wr     = wr_strobe ? high_hit : 2'b00;

  // ==========================================================================
  // Configuration and trim registers
  generate
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
      assign cfg_hit[i] = paddr == ddtr_addr(CFG_IDX[i]);
      assign cfg_wr[i]  = wr_strobe && cfg_hit[i];
      ddtr_byte_reg #(
        .MASK (CFG_MASK[i])
      ) u_cfg (
        .mclk  (mclk),
        .srst  (srst),
        .wr_en (cfg_wr[i]),
        .wdata (pwdata[7:0]),
        .q_reg (cfg_q[i])
      );
    end
  endgenerate

  // One alignment bit steers both channels
  assign left_align_select = cfg_q[CFG_REFAL][ALIGN_BIT];

  // ==========================================================================
  // Shared staging byte, loaded by any low byte write
  assign temp_next = (wr_strobe && (|low_hit)) ? pwdata[7:0] : temp_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      temp_reg <= TEMP_RESET;
    end else begin
      temp_reg <= temp_next;
    end
  end

  // ==========================================================================
  // Two code channels
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      ddtr_code_chan u_chan (
        .mclk       (mclk),
        .srst       (srst),
        .left_align (left_align_select),
        .commit     (high_wr[c]),
        .temp_byte  (temp_reg),
        .wdata      (pwdata[7:0]),
        .consume    (code_taken[c]),
        .code_reg   (code_q[c]),
        .empty_reg  (empty_q[c]),
        .low_rd     (low_rd[c]),
        .high_rd    (high_rd[c])
      );
    end
  endgenerate

  // ==========================================================================
  // Read data selection
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (cfg_hit[i]) begin
        rd_byte = cfg_q[i];
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (low_hit[c]) begin
        rd_byte = low_rd[c];
      end
      if (high_hit[c]) begin
        rd_byte = high_rd[c];
      end
    end
    if (status_hit) begin
      rd_byte = {6'h00, empty_q};
    end
  end

  // Registered answer, one access cycle, error on unmapped address
  assign prdata_next  = setup_ph ? {24'h000000, rd_byte} : prdata_reg;
  assign pready_next  = setup_ph;
  assign pslverr_next = setup_ph ? !mapped : 1'b0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign main_control            = cfg_q[CFG_MAIN];
  assign channel_trigger_control = cfg_q[CFG_TRIG];
  assign reference_align_control = cfg_q[CFG_REFAL];
  assign event_source_select     = cfg_q[CFG_EVSEL];
  assign ch0_gain_trim           = cfg_q[CFG_G0];
  assign ch0_offset_trim         = cfg_q[CFG_O0];
  assign ch1_gain_trim           = cfg_q[CFG_G1];
  assign ch1_offset_trim         = cfg_q[CFG_O1];
  assign ch0_conversion_code     = code_q[0];
  assign ch1_conversion_code     = code_q[1];
  assign ch0_code_empty_flag     = empty_q[0];
  assign ch1_code_empty_flag     = empty_q[1];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_high_right_rsvd: assert property (setup_ph && !pwrite && (|high_hit)
      && !left_align_select |=> prdata[7:4] == 4'h0 && pready)
    else $error("right high byte upper nibble not zero");
  a_low_left_rsvd: assert property (setup_ph && !pwrite && (|low_hit)
      && left_align_select |=> prdata[3:0] == 4'h0 && pready)
    else $error("left low byte lower nibble not zero");
  a_gain0_write: assert property (wr_strobe && cfg_hit[CFG_G0]
      |=> ch0_gain_trim == $past(pwdata[7:0]))
    else $error("channel 0 gain trim not written");
  a_offs0_write: assert property (wr_strobe && cfg_hit[CFG_O0]
      |=> ch0_offset_trim == $past(pwdata[7:0]))
    else $error("channel 0 offset trim not written");
  a_trim1_top_bit: assert property (ch1_gain_trim[7] == 1'b0
      && ch1_offset_trim[7] == 1'b0)
    else $error("channel 1 trim top bit set");
  a_left_8bit_conv: assert property (wr_strobe && high_hit[0]
      && left_align_select |=> ch0_conversion_code[11:4] == $past(pwdata[7:0]))
    else $error("left high byte write not converted");
  a_map_ch1_high: assert property (wr_strobe && paddr == ddtr_addr(IDX_CH1_HIGH)
      |=> $stable(ch0_conversion_code))
    else $error("channel 1 write hit channel 0");
  // Reset check stays armed while reset is high
  a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0) srst |=>
      ch0_conversion_code == 12'h000 && ch1_conversion_code == 12'h000
      && ch0_gain_trim == 8'h00 && ch1_offset_trim == 8'h00)
    else $error("reset did not clear registers");
  a_unmapped_err: assert property (setup_ph && !mapped |=> pslverr && pready)
    else $error("unmapped address not flagged");

  // Bus answer timing and error path
  a_ready_after_setup: assert property (setup_ph |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (!setup_ph |=> !pready && !pslverr)
    else $error("answer without setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_mapped_no_err: assert property (setup_ph && mapped |=> !pslverr)
    else $error("mapped address flagged as error");
  a_err_read_zero: assert property (setup_ph && !mapped |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_err_no_write: assert property (psel && penable && pready && pslverr
      |=> $stable(cfg_q) && $stable(temp_reg))
    else $error("unmapped write changed a register");
  a_cfg_hold: assert property (!wr_strobe |=> $stable(cfg_q))
    else $error("register changed without write");
  a_read_no_change: assert property (setup_ph && !pwrite
      |=> $stable(cfg_q) && $stable(temp_reg))
    else $error("read changed a register");

  // Code byte views in both layouts
  a_high_right_read: assert property (setup_ph && !pwrite && high_hit[0]
      && !left_align_select |=> prdata[3:0] == $past(ch0_conversion_code[11:8]))
    else $error("right high byte read wrong");
  a_high_left_read: assert property (setup_ph && !pwrite && high_hit[1]
      && left_align_select |=> prdata[7:0] == $past(ch1_conversion_code[11:4]))
    else $error("left high byte read wrong");
  a_low_right_read: assert property (setup_ph && !pwrite && low_hit[0]
      && !left_align_select |=> prdata[7:0] == $past(ch0_conversion_code[7:0]))
    else $error("right low byte read wrong");
  a_low_left_read: assert property (setup_ph && !pwrite && low_hit[1]
      && left_align_select |=> prdata[7:4] == $past(ch1_conversion_code[3:0]))
    else $error("left low byte read wrong");

  // Code commit and staging byte
  a_right_commit_ch1: assert property (wr_strobe && high_hit[1]
      && !left_align_select |=> ch1_conversion_code
      == {$past(pwdata[3:0]), $past(temp_reg)})
    else $error("channel 1 right commit wrong");
  a_left_commit_ch1: assert property (wr_strobe && high_hit[1]
      && left_align_select |=> ch1_conversion_code
      == {$past(pwdata[7:0]), $past(temp_reg[7:4])})
    else $error("channel 1 left commit wrong");
  a_staging_load: assert property (wr_strobe && (|low_hit)
      |=> temp_reg == $past(pwdata[7:0]))
    else $error("staging byte not loaded");
  a_low_no_commit: assert property (wr_strobe && (|low_hit)
      |=> $stable(ch0_conversion_code) && $stable(ch1_conversion_code))
    else $error("low byte write changed a code");
  a_map_ch0_high: assert property (wr_strobe && high_hit[0]
      |=> $stable(ch1_conversion_code))
    else $error("channel 0 write hit channel 1");
  a_code_only_commit: assert property (!(wr_strobe && (|high_hit))
      |=> $stable(ch0_conversion_code) && $stable(ch1_conversion_code))
    else $error("code changed without high byte write");

  // Trim, alignment and empty flag registers
  a_gain1_write: assert property (wr_strobe && cfg_hit[CFG_G1]
      |=> ch1_gain_trim == ($past(pwdata[7:0]) & CFG_MASK[CFG_G1]))
    else $error("channel 1 gain trim not written");
  a_offs1_write: assert property (wr_strobe && cfg_hit[CFG_O1]
      |=> ch1_offset_trim == ($past(pwdata[7:0]) & CFG_MASK[CFG_O1]))
    else $error("channel 1 offset trim not written");
  a_trim_hold: assert property (!wr_strobe |=> $stable(ch0_gain_trim)
      && $stable(ch0_offset_trim) && $stable(ch1_gain_trim) && $stable(ch1_offset_trim))
    else $error("trim changed without write");
  a_align_write: assert property (wr_strobe && cfg_hit[CFG_REFAL]
      |=> left_align_select == $past(pwdata[ALIGN_BIT]))
    else $error("align bit not taken from write");
  a_status_read: assert property (setup_ph && !pwrite && status_hit
      |=> prdata[7:0] == {6'h00, $past(ch1_code_empty_flag), $past(ch0_code_empty_flag)})
    else $error("empty flags read wrong");
  a_status_no_write: assert property (wr_strobe && status_hit && code_taken == 2'b00
      |=> $stable(ch0_code_empty_flag) && $stable(ch1_code_empty_flag))
    else $error("empty flags changed by a write");
  a_take_sets_flag1: assert property (code_taken[1] |=> ch1_code_empty_flag)
    else $error("channel 1 empty flag not set by take");
  a_take_sets_flag0: assert property (code_taken[0] |=> ch0_code_empty_flag)
    else $error("channel 0 empty flag not set by take");

  c_left_write: cover property (wr_strobe && (|high_hit) && left_align_select);
  c_right_write: cover property (wr_strobe && (|high_hit) && !left_align_select);
  c_trim_write: cover property (wr_strobe && cfg_hit[CFG_O1]);
  c_status_read: cover property (setup_ph && status_hit && !pwrite);

endmodule

// file: ddtr_top_test.sv
// Self-checking testbench for the converter data and trim register bank
`timescale 1ns/1ps
module ddtr_top_test
  import ddtr_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  code_taken;
  logic [7:0]  c_main, c_trig, c_ref, c_ev, g0, o0, g1, o1;
  logic [11:0] ch0_code, ch1_code;
  logic        ch0_empty, ch1_empty;
  int          bad_count;
  int          total_checks;

  ddtr_top ddtr_top_i (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .code_taken(code_taken), .main_control(c_main),
    .channel_trigger_control(c_trig), .reference_align_control(c_ref),
    .event_source_select(c_ev), .ch0_gain_trim(g0), .ch0_offset_trim(o0),
    .ch1_gain_trim(g1), .ch1_offset_trim(o1), .ch0_conversion_code(ch0_code),
    .ch1_conversion_code(ch1_code), .ch0_code_empty_flag(ch0_empty),
    .ch1_code_empty_flag(ch1_empty));

  // ==========================================================================
  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================================================
  // Shared tasks
  function automatic logic [7:0] ba(input logic [5:0] idx);
    ba = {idx, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) bad_count++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, exp});
    chk({31'h0, e}, 32'h0);
  endtask

  // Low byte then high byte of one channel, then code and both reads
  task automatic code_case(input int ch, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [11:0] code, input logic [7:0] rlo,
                           input logic [7:0] rhi);
    logic [7:0] a;
    a = (ch == 1) ? ba(IDX_CH1_LOW) : ba(IDX_CH0_LOW);
    wr(a, lo);
    wr(a + 8'h04, hi);
    @(negedge mclk);
    chk({20'h0, (ch == 1) ? ch1_code : ch0_code}, {20'h0, code});
    rd(a, rlo);
    rd(a + 8'h04, rhi);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    @(negedge mclk);
    chk({g0, o0, g1, o1}, 32'h0);
    chk({8'h0, ch0_code, ch1_code}, 32'h0);
    rd(ba(IDX_CH0_LOW), 8'h00);
    rd(ba(IDX_CH1_HIGH), 8'h00);
    rd(ba(IDX_CH1_OFFS), 8'h00);
  endtask

  task automatic t_trims();
    wr(ba(IDX_CH0_GAIN), 8'ha5);
    wr(ba(IDX_CH0_OFFS), 8'hff);
    wr(ba(IDX_CH1_GAIN), 8'h7f);
    wr(ba(IDX_CH1_OFFS), 8'h5a);
    wr(ba(IDX_MAIN_CTRL), 8'h1f);
    wr(ba(IDX_TRIG_CTRL), 8'h63);
    wr(ba(IDX_EVENT_SEL), 8'h0f);
    @(negedge mclk);
    chk({g0, o0, g1, o1}, 32'ha5ff7f5a);
    chk({c_main, c_trig, c_ref, c_ev}, 32'h1f63000f);
    rd(ba(IDX_TRIG_CTRL), 8'h63);
    rd(ba(IDX_CH0_GAIN), 8'ha5);
    rd(ba(IDX_CH0_OFFS), 8'hff);
    rd(ba(IDX_CH1_GAIN), 8'h7f);
    rd(ba(IDX_CH1_OFFS), 8'h5a);
  endtask

  task automatic t_right();
    code_case(0, 8'hab, 8'h0c, 12'hcab, 8'hab, 8'h0c);
    code_case(1, 8'h34, 8'h07, 12'h734, 8'h34, 8'h07);
  endtask

  task automatic t_left();
    wr(ba(IDX_REF_ALIGN), 8'h01);
    @(negedge mclk);
    chk({24'h0, c_ref}, 32'h01);
    rd(ba(IDX_CH0_HIGH), 8'hca);
    rd(ba(IDX_CH0_LOW), 8'hb0);
    code_case(1, 8'h50, 8'h9e, 12'h9e5, 8'h50, 8'h9e);
    code_case(1, 8'h00, 8'h3c, 12'h3c0, 8'h00, 8'h3c);
    wr(ba(IDX_CH0_HIGH), 8'h7e);
    @(negedge mclk);
    chk({20'h0, ch0_code}, 32'h7e0);
  endtask

  task automatic t_empty();
    chk({30'h0, ch1_empty, ch0_empty}, 32'h0);
    @(posedge mclk);
    code_taken <= 2'b11;
    @(posedge mclk);
    code_taken <= 2'b00;
    @(negedge mclk);
    chk({30'h0, ch1_empty, ch0_empty}, 32'h3);
    wr(ba(IDX_EMPTY_FLG), 8'h00);
    rd(ba(IDX_EMPTY_FLG), 8'h03);
    code_case(0, 8'h10, 8'h22, 12'h221, 8'h10, 8'h22);
    chk({30'h0, ch1_empty, ch0_empty}, 32'h2);
    code_case(0, 8'h70, 8'h44, 12'h447, 8'h70, 8'h44);
  endtask

  // Reset in mid-run clears codes, trims, controls and flags
  task automatic t_reset_mid();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk({g0, o0, g1, o1}, 32'h0);
    chk({8'h0, ch0_code, ch1_code}, 32'h0);
    chk({c_main, c_trig, c_ref, c_ev}, 32'h0);
    chk({30'h0, ch1_empty, ch0_empty}, 32'h0);
    rd(ba(IDX_CH0_HIGH), 8'h00);
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 8'h10, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  // ==========================================================================
  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(5000 * 100);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    bad_count    = 0;
    total_checks = 0;
    srst         = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    code_taken   = 2'b00;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_trims();
    t_right();
    t_left();
    t_empty();
    t_reset_mid();
    t_unmapped();
    end_sim();
  end
endmodule
